/* shared/ldm_pkg.sv */
package ldm_pkg;
    // Operating modes, Gray coded along reset-detect-load-run-limp-sleep
    typedef enum logic [2:0] {
        ST_RESET = 3'h0,
        ST_DETECT = 3'h1,
        ST_LOAD = 3'h3,
        ST_RUN = 3'h2,
        ST_LIMP = 3'h6,
        ST_SLEEP = 3'h7,
        ST_STANDALONE = 3'h5
    } ldm_mode_t;

    // One command frame, first bit shifted in at the top
    typedef struct packed {
        logic write;
        logic [5:0] addr;
        logic parity;
        logic [7:0] data;
    } ldm_frame_t;

    // System configuration one, low data bits
    typedef struct packed {
        logic wd_enable;
        logic forced_fallback;
        logic [1:0] chan_enable;
    } ldm_cfg_t;

    // Synchronised pin group
    typedef struct packed {
        logic [1:0] latched;
        logic [1:0] restart;
        logic [1:0] dim;
        logic ref_low;
    } ldm_pins_t;

    localparam int FRAME_BITS = 16;
    localparam int CFG_BITS = 4;
    localparam int WD_COUNTER_BITS = 25;
    localparam int RESTART_CNT_BITS = 20;

    // Register addresses
    localparam logic [5:0] ADDR_SYS_CFG_ONE = 6'h00;
    localparam logic [5:0] ADDR_SLEEP = 6'h01;
    localparam logic [5:0] ADDR_SOFT_RESET = 6'h02;
    localparam logic [5:0] ADDR_WD_TAP = 6'h03;
    localparam logic [5:0] ADDR_FAULT_FLAGS_C = 6'h04;

    // Command codes and fields
    localparam logic [7:0] CODE_RESET_TO_LOAD = 8'hc3;
    localparam logic [7:0] CODE_RESET_TO_DETECT = 8'hd4;
    localparam logic [1:0] SLEEP_ENTER = 2'h1;
    localparam logic [1:0] SLEEP_WAKE = 2'h0;
    localparam logic [7:0] READ_DATA_ZERO = 8'h00;

    // Reset values
    localparam ldm_cfg_t CFG_DEFAULT = 4'h8;
    localparam logic [4:0] WD_TAP_DEFAULT = 5'h18;
    localparam logic [1:0] WD_TIMEOUTS_TO_LIMP = 2'h3;

    // Timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int FAULT_RESTART_NS = 3600000;
endpackage

/* design/ldm_mode_ctrl.sv */
// How it works
// - Undervoltage holds defaults, channels off
// - No good frame in time gives standalone
// - Good frame in detect restarts watchdog, loads
// - Standalone: no watchdog, fallback ref, dim pins
// - Standalone uses default on-time setting
// - Standalone restarts every fault after timer
// - Standalone low reference pin turns channels off
// - Standalone code c3 resets, goes load
// - Standalone flags read, code d4 goes detect
// - Load keeps channel outputs off
// - Load waits for power-cycled flag read
// - Sleep code 01 from load or run
// - Channel enable bit moves load to run
// - Run switching needs forced switch low, no latch
// - Latched fault in run clears enable, discharges, loads
// - Unlatched fault retries after restart timer
// - Three watchdog timeouts in run give limp
// - Forced fallback switch gives limp mode
// - Sleep stops oscillator, converters, switches, channels
// - Sleep only watches sleep register writes
// - Wake code 00 from sleep goes load
// - Limp exit: flags read, switch written low
// - Watchdog on at power-up, tap default 24
module ldm_mode_ctrl
    import ldm_pkg::*;
#(
    parameter int RESTART_CYCLES = FAULT_RESTART_NS / CLK_PERIOD_NS,
    // Detect-phase tap is fixed; only a bench shortens it
    parameter int DETECT_TAP = int'(WD_TAP_DEFAULT)
) (
    // System clock and reset
    input wire logic CLK,
    input wire logic RSTN,
    // Supply undervoltage monitors
    input wire logic UV_ANALOG,
    input wire logic UV_LOGIC,
    // Serial port pins
    input wire logic LINK_SCK,
    input wire logic LINK_SSN_N,
    input wire logic LINK_MOSI,
    // Fallback reference and dimming pins
    input wire logic FALLBACK_REF_LOW,
    input wire logic [1:0] DIM_ENABLE_INPUT,
    // Per-channel fault detectors
    input wire logic [1:0] LATCHED_FAULT,
    input wire logic [1:0] RESTART_FAULT,
    // Mode and channel control
    output ldm_mode_t MODE,
    output logic [1:0] CHANNEL_ON,
    output logic [1:0] CHANNEL_ENABLE_BIT,
    output logic FORCED_FALLBACK_SWITCH,
    output logic LINK_WATCHDOG_ENABLE,
    output logic [4:0] WATCHDOG_TAP_SELECT,
    output logic WATCHDOG_RUNNING,
    output logic USE_FALLBACK_REF,
    output logic DEFAULT_ON_TIME,
    output logic AUTO_RESTART_ALL,
    output logic COMP_DISCHARGE,
    output logic OSC_ENABLE,
    output logic CONVERTER_ENABLE,
    output logic POWER_SWITCH_ENABLE,
    // Status flags
    output logic POWER_CYCLED_FLAG,
    output logic LINK_WATCHDOG_TIMEOUT_FLAG
);

    // Address and direction match of a frame
    function automatic logic hit(ldm_frame_t f, logic [5:0] a, logic wr);
        return (f.addr == a) && (f.write == wr);
    endfunction

    logic por_n_raw; // Any reset source, asynchronous
    logic [1:0] por_sync; // Release synchroniser
    logic rst_n; // System reset, synchronous release

    // Assert at once, release two edges after supplies are good
    assign por_n_raw = RSTN & ~UV_ANALOG & ~UV_LOGIC;
    always_ff @(posedge CLK or negedge por_n_raw) begin
        if (!por_n_raw) begin
            por_sync <= 2'h0;
        end else begin
            por_sync <= {por_sync[0], 1'b1};
        end
    end
    assign rst_n = por_sync[1];

    // Link clock domain; a supply drop clears it too, so the frame toggle
    // and its system-side copy restart together
    logic [FRAME_BITS-1:0] shift; // Last sixteen bits in
    logic [3:0] bit_cnt; // Clock count modulo sixteen
    logic full; // At least sixteen clocks seen
    logic frame_tog; // Toggles on first clock of a frame
    logic armed; // Cleared while select is high
    logic arm_clr_n;

    // Select high clears the arm flag without a clock
    assign arm_clr_n = por_n_raw & ~LINK_SSN_N;
    always_ff @(posedge LINK_SCK or negedge arm_clr_n) begin
        if (!arm_clr_n) begin
            armed <= 1'b0;
        end else begin
            armed <= 1'b1;
        end
    end

    // Shift in, msb first, and count clocks
    always_ff @(posedge LINK_SCK or negedge por_n_raw) begin
        if (!por_n_raw) begin
            shift <= '0;
            bit_cnt <= 4'h0;
            full <= 1'b0;
            frame_tog <= 1'b0;
        end else begin
            shift <= {shift[FRAME_BITS-2:0], LINK_MOSI};
            if (!armed) begin
                // First clock of a new frame
                bit_cnt <= 4'h1;
                full <= 1'b0;
                frame_tog <= ~frame_tog;
            end else begin
                bit_cnt <= bit_cnt + 4'h1;
                if (bit_cnt == 4'hf) begin
                    full <= 1'b1;
                end
            end
        end
    end

    // System clock domain
    logic [1:0] ssn_sync; // Select synchroniser
    logic ssn_prev; // Edge detect on synced select
    logic [1:0] tog_sync; // Frame toggle synchroniser
    logic tog_seen; // Toggle value at the last frame end
    ldm_pins_t pin_meta; // Pin synchroniser, first stage
    ldm_pins_t pins; // Pin synchroniser, second stage

    // Two flops on select, frame toggle and pins
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            ssn_sync <= 2'h3;
            ssn_prev <= 1'b1;
            tog_sync <= 2'h0;
            pin_meta <= '0;
            pins <= '0;
        end else begin
            ssn_sync <= {ssn_sync[0], LINK_SSN_N};
            ssn_prev <= ssn_sync[1];
            tog_sync <= {tog_sync[0], frame_tog};
            pin_meta <= {LATCHED_FAULT, RESTART_FAULT, DIM_ENABLE_INPUT, FALLBACK_REF_LOW};
            pins <= pin_meta;
        end
    end

    logic frame_end; // Select seen rising
    ldm_frame_t frame; // Received frame
    logic frame_good; // Whole, clocked, parity and read data fine
    ldm_cfg_t wr_val; // Frame data as configuration

    // Shift and count are quiet while select is high, and the synced
    // edge comes two cycles late, so reading them here is safe; a host
    // clocking with select high would break this
    assign frame_end = ssn_sync[1] & ~ssn_prev;
    assign frame = ldm_frame_t'(shift);
    assign wr_val = ldm_cfg_t'(frame.data[CFG_BITS-1:0]);
    assign frame_good = frame_end && (tog_sync[1] != tog_seen) && full && (bit_cnt == 4'h0)
        && (^shift) && (frame.write || frame.data == READ_DATA_ZERO);

    // Remember toggle so a frame with no clocks is refused
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            tog_seen <= 1'b0;
        end else if (frame_end) begin
            tog_seen <= tog_sync[1];
        end
    end

    ldm_mode_t mode; // The one mode register
    ldm_mode_t next_mode;
    ldm_cfg_t cfg; // System configuration one
    logic [4:0] wd_tap; // Watchdog tap select
    logic pc_flag; // Power-cycled flag
    logic wdto_flag; // Watchdog timeout flag
    logic awake; // Frames other than sleep are honoured

    logic wr_cfg, wr_sleep, wr_reset, wr_tap, rd_flags;
    logic soft_to_load, soft_to_detect, soft_reset;
    logic sleep_enter, wake;

    // Command decode; asleep only the sleep register listens
    assign awake = (mode != ST_SLEEP);
    assign wr_cfg = frame_good && awake && hit(frame, ADDR_SYS_CFG_ONE, 1'b1);
    assign wr_sleep = frame_good && hit(frame, ADDR_SLEEP, 1'b1);
    assign wr_reset = frame_good && awake && hit(frame, ADDR_SOFT_RESET, 1'b1);
    assign wr_tap = frame_good && awake && hit(frame, ADDR_WD_TAP, 1'b1);
    assign rd_flags = frame_good && awake && hit(frame, ADDR_FAULT_FLAGS_C, 1'b0);
    assign soft_to_load = (mode == ST_STANDALONE) && wr_reset
        && (frame.data == CODE_RESET_TO_LOAD);
    assign soft_to_detect = (mode == ST_STANDALONE) && wr_reset && !wdto_flag
        && (frame.data == CODE_RESET_TO_DETECT);
    assign soft_reset = soft_to_load | soft_to_detect;
    assign sleep_enter = ((mode == ST_LOAD) || (mode == ST_RUN)) && wr_sleep
        && (frame.data[1:0] == SLEEP_ENTER);
    assign wake = (mode == ST_SLEEP) && wr_sleep && (frame.data[1:0] == SLEEP_WAKE);

    logic [1:0] latch_hit; // Latched fault on an enabled channel
    logic latched_stop; // Run mode must drop back to load
    assign latch_hit = pins.latched & cfg.chan_enable;
    assign latched_stop = (mode == ST_RUN) && (latch_hit != 2'h0);

    // Watchdog counter and tap
    logic [WD_COUNTER_BITS-1:0] wd_cnt;
    logic wd_run; // Watchdog counting
    logic wd_expire; // Tap bit reached
    logic [1:0] to_cnt; // Consecutive run timeouts
    logic limp_by_wd;

    // Detect always watches; standalone and sleep never do
    assign wd_run = (mode == ST_DETECT) || (cfg.wd_enable && ((mode == ST_LOAD)
        || (mode == ST_RUN) || (mode == ST_LIMP)));
    // Detect waits a fixed span; later modes use the tap register
    assign wd_expire = wd_run && ((mode == ST_DETECT) ? wd_cnt[DETECT_TAP]
        : wd_cnt[wd_tap]);
    assign limp_by_wd = (mode == ST_RUN) && cfg.wd_enable && wd_expire
        && (to_cnt == WD_TIMEOUTS_TO_LIMP - 2'h1);

    // Count up, restart on good frame or expiry
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            wd_cnt <= '0;
        end else if (!wd_run || frame_good || wd_expire) begin
            wd_cnt <= '0;
        end else begin
            wd_cnt <= wd_cnt + 25'h1;
        end
    end

    // Consecutive timeouts, broken by any good frame
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            to_cnt <= 2'h0;
        end else if (frame_good || mode != ST_RUN) begin
            to_cnt <= 2'h0;
        end else if (wd_expire) begin
            to_cnt <= to_cnt + 2'h1;
        end
    end

    // Configuration registers
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            cfg <= CFG_DEFAULT;
            wd_tap <= WD_TAP_DEFAULT;
        end else if (soft_reset) begin
            cfg <= CFG_DEFAULT;
            wd_tap <= WD_TAP_DEFAULT;
        end else begin
            if (wr_cfg) begin
                cfg <= wr_val;
            end
            if (wr_tap) begin
                wd_tap <= frame.data[4:0];
            end
            if (sleep_enter) begin
                cfg.chan_enable <= 2'h0;
            end else if (latched_stop) begin
                cfg.chan_enable <= cfg.chan_enable & ~latch_hit;
            end
        end
    end

    // Status flags: a set in the clearing cycle wins
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            pc_flag <= 1'b1;
            wdto_flag <= 1'b0;
        end else begin
            if (soft_reset) begin
                pc_flag <= 1'b1;
            end else if (rd_flags) begin
                pc_flag <= 1'b0;
            end
            if (wd_expire) begin
                wdto_flag <= 1'b1;
            end else if (rd_flags || soft_reset) begin
                wdto_flag <= 1'b0;
            end
        end
    end

    // Mode transitions
    always_comb begin
        next_mode = mode;
        case (mode)
            ST_RESET: begin
                next_mode = ST_DETECT;
            end
            ST_DETECT: begin
                if (frame_good) begin
                    next_mode = ST_LOAD;
                end else if (wd_expire) begin
                    next_mode = ST_STANDALONE;
                end
            end
            ST_STANDALONE: begin
                if (soft_to_load) begin
                    next_mode = ST_LOAD;
                end else if (soft_to_detect) begin
                    next_mode = ST_DETECT;
                end
            end
            ST_LOAD: begin
                if (sleep_enter) begin
                    next_mode = ST_SLEEP;
                end else if (!pc_flag && cfg.chan_enable != 2'h0) begin
                    next_mode = ST_RUN;
                end
            end
            ST_RUN: begin
                if (sleep_enter) begin
                    next_mode = ST_SLEEP;
                end else if (latched_stop) begin
                    next_mode = ST_LOAD;
                end else if (cfg.forced_fallback || limp_by_wd) begin
                    next_mode = ST_LIMP;
                end
            end
            ST_LIMP: begin
                // Flags must already be read when the switch is dropped
                if (wr_cfg && !wr_val.forced_fallback && !wdto_flag) begin
                    next_mode = ST_RUN;
                end
            end
            ST_SLEEP: begin
                if (wake) begin
                    next_mode = ST_LOAD;
                end
            end
            default: begin
                next_mode = ST_RESET;
            end
        endcase
    end

    // Mode register
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            mode <= ST_RESET;
        end else begin
            mode <= next_mode;
        end
    end

    // Restart timers, one per channel
    logic [RESTART_CNT_BITS-1:0] rs_cnt [2];
    logic [1:0] rs_busy;
    logic [1:0] retry_fault; // Faults that auto-restart now
    assign retry_fault = pins.restart
        | ((mode == ST_STANDALONE) ? pins.latched : 2'h0);
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            rs_cnt[0] <= '0;
            rs_cnt[1] <= '0;
        end else begin
            for (int ch = 0; ch < 2; ch++) begin
                if (retry_fault[ch]) begin
                    rs_cnt[ch] <= RESTART_CNT_BITS'(RESTART_CYCLES);
                end else if (rs_busy[ch]) begin
                    rs_cnt[ch] <= rs_cnt[ch] - 20'h1;
                end
            end
        end
    end
    assign rs_busy = {rs_cnt[1] != '0, rs_cnt[0] != '0};

    // Channel drive for the coming mode
    logic [1:0] next_chan_on;
    always_comb begin
        case (next_mode)
            ST_RUN: begin
                next_chan_on = cfg.chan_enable & ~pins.latched & ~rs_busy
                    & {2{!cfg.forced_fallback}};
            end
            ST_LIMP: begin
                next_chan_on = cfg.chan_enable & ~rs_busy;
            end
            ST_STANDALONE: begin
                next_chan_on = pins.dim & ~rs_busy
                    & {2{!pins.ref_low}};
            end
            default: begin
                next_chan_on = 2'h0;
            end
        endcase
    end

    // Registered mode-dependent outputs
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            CHANNEL_ON <= 2'h0;
            USE_FALLBACK_REF <= 1'b0;
            DEFAULT_ON_TIME <= 1'b0;
            AUTO_RESTART_ALL <= 1'b0;
            COMP_DISCHARGE <= 1'b0;
            OSC_ENABLE <= 1'b1;
            CONVERTER_ENABLE <= 1'b0;
            POWER_SWITCH_ENABLE <= 1'b0;
        end else begin
            CHANNEL_ON <= next_chan_on;
            USE_FALLBACK_REF <= (next_mode == ST_STANDALONE) || (next_mode == ST_LIMP);
            DEFAULT_ON_TIME <= (next_mode == ST_STANDALONE);
            AUTO_RESTART_ALL <= (next_mode == ST_STANDALONE);
            COMP_DISCHARGE <= latched_stop;
            OSC_ENABLE <= (next_mode != ST_SLEEP);
            CONVERTER_ENABLE <= (next_mode != ST_SLEEP) && (next_mode != ST_RESET);
            POWER_SWITCH_ENABLE <= (next_mode != ST_SLEEP) && (next_mode != ST_RESET);
        end
    end

    assign MODE = mode;
    assign CHANNEL_ENABLE_BIT = cfg.chan_enable;
    assign FORCED_FALLBACK_SWITCH = cfg.forced_fallback;
    assign LINK_WATCHDOG_ENABLE = cfg.wd_enable;
    assign WATCHDOG_TAP_SELECT = wd_tap;
    assign WATCHDOG_RUNNING = wd_run;
    assign POWER_CYCLED_FLAG = pc_flag;
    assign LINK_WATCHDOG_TIMEOUT_FLAG = wdto_flag;

    // Checks, system domain
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!rst_n);

    a_reset_leaves_detect: assert property (mode == ST_RESET |=> mode == ST_DETECT)
        else $error("reset mode not followed by detect");
    a_detect_frame_load: assert property (mode == ST_DETECT && frame_good
        |=> mode == ST_LOAD && wd_cnt == '0)
        else $error("good frame in detect did not load");
    a_detect_timeout: assert property (mode == ST_DETECT && wd_expire && !frame_good
        |=> mode == ST_STANDALONE && !wd_run)
        else $error("watchdog expiry did not enter standalone");
    a_standalone_ref_off: assert property (mode == ST_STANDALONE && pins.ref_low
        ##1 mode == ST_STANDALONE |-> CHANNEL_ON == 2'h0)
        else $error("channel on with low reference pin");
    a_run_switch_gate: assert property (mode == ST_RUN && CHANNEL_ON != 2'h0
        |-> !$past(cfg.forced_fallback))
        else $error("switching with forced fallback switch set");
    a_latch_to_load: assert property (latched_stop && !sleep_enter
        |=> mode == ST_LOAD && COMP_DISCHARGE ##1 !COMP_DISCHARGE)
        else $error("latched fault did not return to load");
    a_forced_limp: assert property (mode == ST_RUN && cfg.forced_fallback
        && !sleep_enter && !latched_stop |=> mode == ST_LIMP)
        else $error("forced switch did not enter limp");
    a_sleep_quiet: assert property (mode == ST_SLEEP |-> !OSC_ENABLE && !CONVERTER_ENABLE
        && !POWER_SWITCH_ENABLE && CHANNEL_ON == 2'h0 && cfg.chan_enable == 2'h0)
        else $error("sleep left something running");
    a_wake_to_load: assert property (wake |=> mode == ST_LOAD)
        else $error("wake write did not reach load");
    a_load_needs_read: assert property (mode == ST_LOAD && pc_flag |=> mode != ST_RUN)
        else $error("left load with power-cycled flag set");

    c_detect_load: cover property (mode == ST_DETECT ##1 mode == ST_LOAD);
    c_standalone: cover property (mode == ST_DETECT ##1 mode == ST_STANDALONE);
    c_run_limp: cover property (mode == ST_RUN ##1 mode == ST_LIMP);
    c_sleep_wake: cover property (mode == ST_SLEEP ##1 mode == ST_LOAD);
endmodule

/* dv/ldm_host_model.sv */
module ldm_host_model
    import ldm_pkg::*;
(
    // Serial port pins toward the device
    output logic LINK_SCK,
    output logic LINK_SSN_N,
    output logic LINK_MOSI
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle bus: deselected, clock still
    initial begin
        LINK_SCK = 1'b0;
        LINK_SSN_N = 1'b1;
        LINK_MOSI = 1'b0;
    end

    // One frame at 15 ns per bit, msb first; clock runs only inside it
    task automatic send(input logic wr, input logic [5:0] addr, input logic [7:0] data);
        ldm_frame_t f;
        f = '{write: wr, addr: addr, parity: ~^{wr, addr, data}, data: data};
        LINK_SSN_N = 1'b0;
        for (int i = FRAME_BITS - 1; i >= 0; i--) begin
            LINK_MOSI = f[i];
            #7.5 LINK_SCK = 1'b1;
            #7.5 LINK_SCK = 1'b0;
        end
        #7.5 LINK_SSN_N = 1'b1;
        // Released line flips, so a stale bit never looks like data
        LINK_MOSI = ~LINK_MOSI;
    endtask

    // Open-load case from {overvoltage, min off, boot low, high, low, short}
    function automatic logic [1:0] open_load_case(input logic [5:0] f);
        if (f[4] && f[3:0] == 4'hf) return 2'h3;
        if (f == 6'h30) return 2'h1;
        if (f == 6'h10) return 2'h2;
        return 2'h0;
    endfunction
endmodule

/* dv/led_driver_mode_controller_tb.sv */
module led_driver_mode_controller_tb
    import ldm_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    // Clock, reset and pins
    logic CLK, RSTN, uv_a, uv_l, ref_low, sck, ssn_n, mosi;
    logic [1:0] dim, latched, restart, chan_on, en_bit;
    logic forced, wd_en, wd_run, fb_ref, def_on, auto_rs, disch, osc, conv, psw, pc, wd_to;
    logic [4:0] tap;
    ldm_mode_t mode;
    int mismatches = 0;
    int checks_done = 0;

    ldm_mode_ctrl #(.RESTART_CYCLES(20), .DETECT_TAP(8)) i_ldm_mode_ctrl (
        .CLK(CLK), .RSTN(RSTN), .UV_ANALOG(uv_a), .UV_LOGIC(uv_l),
        .LINK_SCK(sck), .LINK_SSN_N(ssn_n), .LINK_MOSI(mosi),
        .FALLBACK_REF_LOW(ref_low), .DIM_ENABLE_INPUT(dim),
        .LATCHED_FAULT(latched), .RESTART_FAULT(restart), .MODE(mode),
        .CHANNEL_ON(chan_on), .CHANNEL_ENABLE_BIT(en_bit), .FORCED_FALLBACK_SWITCH(forced),
        .LINK_WATCHDOG_ENABLE(wd_en), .WATCHDOG_TAP_SELECT(tap), .WATCHDOG_RUNNING(wd_run),
        .USE_FALLBACK_REF(fb_ref), .DEFAULT_ON_TIME(def_on), .AUTO_RESTART_ALL(auto_rs),
        .COMP_DISCHARGE(disch), .OSC_ENABLE(osc), .CONVERTER_ENABLE(conv),
        .POWER_SWITCH_ENABLE(psw), .POWER_CYCLED_FLAG(pc), .LINK_WATCHDOG_TIMEOUT_FLAG(wd_to));
    ldm_host_model i_ldm_host_model (.LINK_SCK(sck), .LINK_SSN_N(ssn_n), .LINK_MOSI(mosi));

    // 250 MHz system clock
    initial begin
        CLK = 1'b0;
        forever #2 CLK = ~CLK;
    end

    // Counted compare, unknowns never match
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic chk_mode(input ldm_mode_t exp);
        chk("mode", 8'(exp), 8'(mode));
    endtask
    // Frame, then settle time well past the select-high spacing
    task automatic wr(input logic w, input logic [5:0] a, input logic [7:0] d);
        i_ldm_host_model.send(w, a, d);
        repeat (8) @(posedge CLK);
        #1;
    endtask
    // Wait a bounded number of edges for a mode
    task automatic wait_mode(input ldm_mode_t m, input int lim);
        for (int n = 0; n < lim && mode !== m; n++) @(posedge CLK);
        #1;
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Hang guard, well beyond the watchdog wait
    initial begin
        #160000;
        mismatches++;
        close_out();
    end

    // Main sequence
    initial begin
        {RSTN, uv_a, uv_l, ref_low, latched, restart} = '0;
        dim = 2'h3;
        repeat (16) @(posedge CLK);
        RSTN <= 1'b1;
        repeat (6) @(posedge CLK);
        #1;
        chk_mode(ST_DETECT);
        chk("pc", 8'h01, 8'(pc));
        chk("wd_en", 8'h01, 8'(wd_en));
        chk("tap", 8'h18, 8'(tap));
        // Silent host: detect runs out into standalone
        wait_mode(ST_STANDALONE, 600);
        chk_mode(ST_STANDALONE);
        chk("wd_to_sa", 8'h01, 8'(wd_to));
        chk("sa_drive", 8'h07, {4'h0, wd_run, fb_ref, chan_on});
        chk("sa_ontime", 8'h01, 8'(def_on));
        chk("sa_restart", 8'h01, 8'(auto_rs));
        @(posedge CLK) ref_low <= 1'b1;
        repeat (4) @(posedge CLK);
        #1 chk("sa_low", 8'h00, 8'(chan_on));
        // Latched-type fault on channel 0 auto-restarts here
        @(posedge CLK) {ref_low, latched} <= 3'h1;
        @(posedge CLK) latched <= 2'h0;
        repeat (6) @(posedge CLK);
        #1 chk("sa_retry", 8'h02, 8'(chan_on));
        repeat (40) @(posedge CLK);
        #1 chk("sa_back", 8'h03, 8'(chan_on));
        wr(1'b1, ADDR_SOFT_RESET, CODE_RESET_TO_DETECT);
        chk_mode(ST_STANDALONE);
        wr(1'b0, ADDR_FAULT_FLAGS_C, READ_DATA_ZERO);
        wr(1'b1, ADDR_SOFT_RESET, CODE_RESET_TO_DETECT);
        chk_mode(ST_DETECT);
        wait_mode(ST_STANDALONE, 600);
        wr(1'b1, ADDR_SOFT_RESET, CODE_RESET_TO_LOAD);
        chk_mode(ST_LOAD);
        chk("pc_soft", 8'h01, 8'(pc));
        chk("open_case", 8'h03, 8'(i_ldm_host_model.open_load_case(6'h1f)));
        wr(1'b1, ADDR_WD_TAP, 8'h0a);
        chk_mode(ST_LOAD);
        wr(1'b1, ADDR_SYS_CFG_ONE, 8'h0b);
        chk_mode(ST_LOAD);
        chk("on_load", 8'h00, 8'(chan_on));
        wr(1'b0, ADDR_FAULT_FLAGS_C, READ_DATA_ZERO);
        chk("pc_read", 8'h00, 8'(pc));
        wr(1'b1, ADDR_SYS_CFG_ONE, 8'h0b);
        chk_mode(ST_RUN);
        chk("on_run", 8'h03, 8'(chan_on));
        // Restart fault on channel 0 only
        @(posedge CLK) restart <= 2'h1;
        @(posedge CLK) restart <= 2'h0;
        repeat (6) @(posedge CLK);
        #1 chk("on_retry", 8'h02, 8'(chan_on));
        repeat (40) @(posedge CLK);
        #1 chk("on_back", 8'h03, 8'(chan_on));
        wr(1'b1, ADDR_SYS_CFG_ONE, 8'h0f);
        chk_mode(ST_LIMP);
        chk("forced", 8'h01, 8'(forced));
        wr(1'b0, ADDR_FAULT_FLAGS_C, READ_DATA_ZERO);
        wr(1'b1, ADDR_SYS_CFG_ONE, 8'h0b);
        chk_mode(ST_RUN);
        @(posedge CLK) latched <= 2'h3;
        repeat (3) @(posedge CLK);
        #1 chk("disch", 8'h01, 8'(disch));
        repeat (3) @(posedge CLK);
        #1 chk_mode(ST_LOAD);
        chk("en_latch", 8'h00, 8'(en_bit));
        @(posedge CLK) latched <= 2'h0;
        wr(1'b1, ADDR_SYS_CFG_ONE, 8'h0b);
        wr(1'b1, ADDR_SLEEP, {6'h00, SLEEP_ENTER});
        chk_mode(ST_SLEEP);
        chk("sleep_out", 8'h00, {1'b0, en_bit, osc, conv, psw, chan_on});
        wr(1'b1, ADDR_SYS_CFG_ONE, 8'h0b);
        chk_mode(ST_SLEEP);
        chk("en_sleep", 8'h00, 8'(en_bit));
        wr(1'b1, ADDR_SLEEP, {6'h00, SLEEP_WAKE});
        chk_mode(ST_LOAD);
        wr(1'b1, ADDR_SYS_CFG_ONE, 8'h0b);
        // Silent host: three watchdog expiries of 1025 cycles
        wait_mode(ST_LIMP, 5000);
        chk_mode(ST_LIMP);
        chk("wd_to", 8'h01, 8'(wd_to));
        // Logic supply drop in limp mode
        @(posedge CLK) uv_l <= 1'b1;
        #1 chk_mode(ST_RESET);
        chk("uv_out", 8'h01, {3'h0, en_bit, chan_on, pc});
        @(posedge CLK) uv_l <= 1'b0;
        repeat (6) @(posedge CLK);
        #1 chk_mode(ST_DETECT);
        wr(1'b1, ADDR_SYS_CFG_ONE, 8'h08);
        chk_mode(ST_LOAD);
        close_out();
    end
endmodule
